// >>> common/cljd_pkg.sv
package cljd_pkg;

	localparam int XLEN = 32;

	// instruction class, supplied by the upstream predecoder
	typedef enum logic [2:0] {
		OP_OTHER16 = 3'h0,
		OP_JRC = 3'h1,
		OP_LBU = 3'h2,
		OP_LHU = 3'h3,
		OP_LI = 3'h4,
		OP_LW = 3'h5,
		OP_LWP = 3'h6,
		OP_LWM = 3'h7
	} cljd_op_e;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_HALF = 2'h1,
		SZ_WORD = 2'h2
	} cljd_size_e;

	typedef enum logic [2:0] {
		FLT_NONE = 3'h0,
		FLT_REFILL = 3'h1,
		FLT_INVALID = 3'h2,
		FLT_BUS = 3'h3,
		FLT_ADDR_LOAD = 3'h4,
		FLT_ADDR_FETCH = 3'h5,
		FLT_WATCH = 3'h6,
		FLT_RESERVED = 3'h7
	} cljd_fault_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01
	} cljd_state_e;

	typedef struct packed {
		cljd_op_e op;
		logic [31:0] instr;
		logic [31:0] src;
	} cljd_issue_s;

	typedef struct packed {
		logic [31:0] addr;
		cljd_size_e size;
	} cljd_mem_req_s;

	typedef struct packed {
		logic [31:0] data;
		cljd_fault_e fault;
	} cljd_mem_rsp_s;

	typedef struct packed {
		logic [4:0] idx;
		logic [31:0] data;
	} cljd_wb_s;

	typedef struct packed {
		cljd_fault_e code;
		logic [31:0] vaddr;
	} cljd_fault_s;

	// field positions
	localparam int F16_RT_LSB = 7;
	localparam int F16_BASE_LSB = 4;
	localparam int F16_JRS_LSB = 5;
	localparam int F32_RD_LSB = 21;
	// register numbers and steps
	localparam logic [4:0] GPR_LIST_BASE = 5'h10;
	localparam logic [4:0] GPR_LIST_FP = 5'h1e;
	localparam logic [4:0] GPR_RA = 5'h1f;
	localparam logic [3:0] LIST_FP_COUNT = 4'h9;
	localparam logic [3:0] LIST_LOW_COUNT = 4'h8;
	localparam logic [31:0] PC_STEP16 = 32'h2;
	localparam logic [31:0] PC_STEP32 = 32'h4;
	localparam logic [31:0] WORD_STEP = 32'h4;
	localparam logic [31:0] PC_RESET = 32'h0;
	localparam logic ISA_RESET = 1'b1;
	localparam logic [3:0] BOFF_NEG_ENC = 4'hf;
	localparam logic [6:0] IMM_NEG_ENC = 7'h7f;

endpackage

// >>> rtl/cljd_core.sv
// What this block does
// (RULE1) single-encoding core: source bit 0 clear gives an address fault at target fetch
// (RULE2) dual-encoding core: bit 0 goes to the mode flag, target bit 0 cleared
// (RULE3) wide mode target with address bit 1 set faults at target fetch
// (RULE4) compact jump has no delay slot; the sequential successor is flushed
// (RULE5) any instruction, even a jump, is accepted right after a jump
// (RULE6) byte offset code 0..e means 0..14, f means minus one, added to base
// (RULE7) unsigned byte load writes the zero-extended byte
// (RULE8) unsigned half load uses offset times two, writes zero-extended halfword
// (RULE9) three-bit register codes select only registers 2..7, 16 and 17
// (RULE10) before release six an odd halfword address faults
// (RULE11) release six may handle misaligned half, word and pair loads in hardware
// (RULE12) immediate code 0..7e means 0..126, 7f means minus one, sign-extended
// (RULE13) load immediate never raises an overflow
// (RULE14) pair load: base plus signed 12-bit offset into rd, next word into rd+1
// (RULE15) software must not use rd 31 or base equal to rd for a pair load
// (RULE16) before release six word and pair loads fault on nonzero low address bits
// (RULE17) short word load uses offset times four, writes the 32-bit word
// (RULE18) multi load adds signed 12-bit offset, loads words into listed registers
// (RULE19) interrupts masking during pair and multi loads is fixed by the implementation
// (RULE20) word, pair and multi loads report translation, bus, address and watch faults
// (RULE21) multi load pairs registers with addresses in list order, one word apart
// (RULE22) list field: count from 16, 30 at top count, 31 when top bit set
// (RULE23) non-redirecting compact instructions advance the program counter by two
`timescale 1ns/1ps
module cljd_core #(
	parameter bit HAS_WIDE_ISA = 1'b1,
	parameter bit IS_RELEASE6 = 1'b1,
	parameter bit MISALIGN_HW = 1'b0
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic issue_valid_i,
	input wire cljd_pkg::cljd_issue_s issue_i,
	output logic issue_ready_o,
	output logic mem_req_valid_o,
	output cljd_pkg::cljd_mem_req_s mem_req_o,
	input wire logic mem_rsp_valid_i,
	input wire cljd_pkg::cljd_mem_rsp_s mem_rsp_i,
	output logic wb_valid_o,
	output cljd_pkg::cljd_wb_s wb_o,
	output logic redirect_o,
	output logic flush_o,
	output logic [31:0] pc_o,
	output logic encoding_select_flag_o,
	output logic fault_valid_o,
	output cljd_pkg::cljd_fault_s fault_o,
	output logic done_o,
	output logic irq_mask_o
);

	if (!IS_RELEASE6 && MISALIGN_HW) begin : g_bad_cfg
		$error("misaligned load support needs release six");
	end

	function automatic logic [4:0] map3(input logic [2:0] e);
		map3 = (e[2:1] == 2'b00) ? {4'b1000, e[0]} : {2'b00, e}; // see (RULE9)
	endfunction

	function automatic logic [31:0] dec_boff(input logic [3:0] e);
		dec_boff = (e == cljd_pkg::BOFF_NEG_ENC) ? 32'hffffffff : {28'h0, e}; // see (RULE6)
	endfunction

	function automatic logic [31:0] dec_imm(input logic [6:0] e);
		dec_imm = (e == cljd_pkg::IMM_NEG_ENC) ? 32'hffffffff : {25'h0, e}; // see (RULE12)
	endfunction

	// register for list position i when cnt low registers are listed
	function automatic logic [4:0] list_reg(input logic [3:0] cnt, input logic [3:0] i);
		if (i >= cnt)
			list_reg = cljd_pkg::GPR_RA; // see (RULE22)
		else if (i < cljd_pkg::LIST_LOW_COUNT)
			list_reg = cljd_pkg::GPR_LIST_BASE + {1'b0, i};
		else
			list_reg = cljd_pkg::GPR_LIST_FP;
	endfunction

	cljd_pkg::cljd_state_e state;
	cljd_pkg::cljd_op_e op_q;
	logic [4:0] dest_q;
	logic [3:0] cnt_q;
	logic [3:0] total_q;
	logic [3:0] idx_q;

	// field decode
	wire [31:0] ins = issue_i.instr;
	wire [31:0] issue_src = issue_i.src;
	wire src_bit0 = issue_src[0];
	wire cljd_pkg::cljd_op_e iop = issue_i.op;
	wire [4:0] rt16 = map3(ins[cljd_pkg::F16_RT_LSB +: 3]);
	wire [3:0] off4 = ins[3:0];
	wire [11:0] off12 = ins[11:0];
	wire [4:0] rd32 = ins[cljd_pkg::F32_RD_LSB +: 5];
	wire [3:0] list_cnt = rd32[3:0];
	wire list_ra = rd32[4];
	wire list_bad = (list_cnt > cljd_pkg::LIST_FP_COUNT) || (list_cnt == 4'h0 && !list_ra);
	wire [3:0] list_total = list_cnt + {3'h0, list_ra};
	wire take = issue_valid_i && issue_ready_o;

	// effective address per load class
	wire [31:0] boff_sext = dec_boff(off4);
	wire [31:0] ea_lbu = issue_src + boff_sext; // see (RULE6)
	wire [31:0] ea_lhu = issue_src + {27'h0, off4, 1'b0}; // see (RULE8)
	wire [31:0] ea_lw = issue_src + {26'h0, off4, 2'b00}; // see (RULE17)
	wire [31:0] ea_12 = issue_src + {{20{off12[11]}}, off12}; // see (RULE14) (RULE18)
	wire [31:0] ea = (iop == cljd_pkg::OP_LBU) ? ea_lbu :
		(iop == cljd_pkg::OP_LHU) ? ea_lhu :
		(iop == cljd_pkg::OP_LW) ? ea_lw : ea_12;
	wire is_half = (iop == cljd_pkg::OP_LHU);
	wire is_word = (iop == cljd_pkg::OP_LW) || (iop == cljd_pkg::OP_LWP) ||
		(iop == cljd_pkg::OP_LWM);
	wire is_seq = (iop == cljd_pkg::OP_LWP) || (iop == cljd_pkg::OP_LWM);
	wire cljd_pkg::cljd_size_e isize = is_word ? cljd_pkg::SZ_WORD :
		is_half ? cljd_pkg::SZ_HALF : cljd_pkg::SZ_BYTE;
	// release six parts without hardware support keep faulting; see (RULE11)
	wire align_fault = !MISALIGN_HW && ((is_half && ea[0]) ||
		(is_word && ea[1:0] != 2'b00)); // see (RULE10) (RULE16)
	wire [4:0] single_dest = (iop == cljd_pkg::OP_LWP) ? rd32 : rt16;
	wire [3:0] beats = (iop == cljd_pkg::OP_LWM) ? list_total :
		(iop == cljd_pkg::OP_LWP) ? 4'h2 : 4'h1;

	// jump target; single-encoding parts always stay in compact mode
	wire [31:0] jtarget = {issue_src[31:1], 1'b0}; // see (RULE2)
	wire jfault = HAS_WIDE_ISA ? (!src_bit0 && issue_src[1]) : !src_bit0; // see (RULE1) (RULE3)
	wire jisa = HAS_WIDE_ISA ? src_bit0 : 1'b1; // see (RULE2)

	// beat decode while loading
	wire rsp_ok = mem_rsp_valid_i && (mem_rsp_i.fault == cljd_pkg::FLT_NONE);
	wire rsp_bad = mem_rsp_valid_i && (mem_rsp_i.fault != cljd_pkg::FLT_NONE);
	wire last_beat = (idx_q + 4'h1) == total_q;
	wire [4:0] beat_dest = (op_q == cljd_pkg::OP_LWP) ? dest_q + {1'b0, idx_q} : // see (RULE14)
		(op_q == cljd_pkg::OP_LWM) ? list_reg(cnt_q, idx_q) : dest_q; // see (RULE21)
	wire [31:0] rdata = mem_rsp_i.data;
	wire [31:0] shaped = (mem_req_o.size == cljd_pkg::SZ_BYTE) ? {24'h0, rdata[7:0]} : // see (RULE7)
		(mem_req_o.size == cljd_pkg::SZ_HALF) ? {16'h0, rdata[15:0]} : rdata; // see (RULE8) (RULE17)
	wire [31:0] step = (op_q == cljd_pkg::OP_LWP || op_q == cljd_pkg::OP_LWM) ?
		cljd_pkg::PC_STEP32 : cljd_pkg::PC_STEP16;
	wire [31:0] req_addr = mem_req_o.addr;
	wire cljd_pkg::cljd_fault_e rsp_fault = mem_rsp_i.fault;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= cljd_pkg::ST_IDLE;
			issue_ready_o <= 1'b0;
			op_q <= cljd_pkg::OP_OTHER16;
			dest_q <= 5'h0;
			cnt_q <= 4'h0;
			total_q <= 4'h0;
			idx_q <= 4'h0;
			mem_req_valid_o <= 1'b0;
			mem_req_o <= '0;
			wb_valid_o <= 1'b0;
			wb_o <= '0;
			redirect_o <= 1'b0;
			flush_o <= 1'b0;
			pc_o <= cljd_pkg::PC_RESET;
			encoding_select_flag_o <= cljd_pkg::ISA_RESET;
			fault_valid_o <= 1'b0;
			fault_o <= '0;
			done_o <= 1'b0;
			irq_mask_o <= 1'b0;
		end else begin
			wb_valid_o <= 1'b0;
			redirect_o <= 1'b0;
			flush_o <= 1'b0;
			fault_valid_o <= 1'b0;
			done_o <= 1'b0;
			case (state)
				cljd_pkg::ST_IDLE: begin
					issue_ready_o <= 1'b1;
					if (take) begin
						case (iop)
							cljd_pkg::OP_JRC: begin
								// no delay slot, ready stays high; see (RULE4) (RULE5)
								redirect_o <= 1'b1;
								flush_o <= 1'b1;
								pc_o <= jtarget;
								encoding_select_flag_o <= jisa;
								done_o <= 1'b1;
								fault_valid_o <= jfault;
								fault_o <= '{cljd_pkg::FLT_ADDR_FETCH, jtarget};
							end
							cljd_pkg::OP_LI: begin
								// plain copy, no adder, so no overflow; see (RULE13)
								wb_valid_o <= 1'b1;
								wb_o <= '{rt16, dec_imm(ins[6:0])};
								pc_o <= pc_o + cljd_pkg::PC_STEP16; // see (RULE23)
								done_o <= 1'b1;
							end
							cljd_pkg::OP_OTHER16: begin
								pc_o <= pc_o + cljd_pkg::PC_STEP16; // see (RULE23)
								done_o <= 1'b1;
							end
							default: begin
								if (iop == cljd_pkg::OP_LWM && list_bad) begin
									fault_valid_o <= 1'b1;
									fault_o <= '{cljd_pkg::FLT_RESERVED, ea};
								end else if (align_fault) begin
									fault_valid_o <= 1'b1; // see (RULE10) (RULE16)
									fault_o <= '{cljd_pkg::FLT_ADDR_LOAD, ea};
								end else begin
									state <= cljd_pkg::ST_LOAD;
									issue_ready_o <= 1'b0;
									mem_req_valid_o <= 1'b1;
									mem_req_o <= '{ea, isize};
									irq_mask_o <= is_seq; // see (RULE19)
									op_q <= iop;
									dest_q <= single_dest;
									cnt_q <= list_cnt;
									total_q <= beats;
									idx_q <= 4'h0;
								end
							end
						endcase
					end
				end
				cljd_pkg::ST_LOAD: begin
					if (rsp_bad) begin
						// abort the sequence; faulting beat writes nothing
						fault_valid_o <= 1'b1; // see (RULE20)
						fault_o <= '{rsp_fault, req_addr};
						mem_req_valid_o <= 1'b0;
						irq_mask_o <= 1'b0;
						state <= cljd_pkg::ST_IDLE;
						issue_ready_o <= 1'b1;
					end else if (rsp_ok) begin
						wb_valid_o <= 1'b1;
						wb_o <= '{beat_dest, shaped};
						if (last_beat) begin
							mem_req_valid_o <= 1'b0;
							irq_mask_o <= 1'b0;
							pc_o <= pc_o + step;
							done_o <= 1'b1;
							state <= cljd_pkg::ST_IDLE;
							issue_ready_o <= 1'b1;
						end else begin
							idx_q <= idx_q + 4'h1;
							mem_req_o.addr <= req_addr + cljd_pkg::WORD_STEP; // see (RULE21)
						end
					end
				end
				default: begin
					state <= cljd_pkg::ST_IDLE;
					issue_ready_o <= 1'b0;
					mem_req_valid_o <= 1'b0;
					irq_mask_o <= 1'b0;
				end
			endcase
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	wire jrc_take = take && iop == cljd_pkg::OP_JRC;

	jump_target_a: assert property ( // see (RULE2) (RULE4)
		jrc_take |=> redirect_o && flush_o && pc_o == ($past(issue_src) & 32'hfffffffe))
		else $error("jump target or flush wrong");
	isa_flag_a: assert property ( // see (RULE2)
		jrc_take && HAS_WIDE_ISA |=> encoding_select_flag_o == $past(src_bit0))
		else $error("mode flag not taken from source bit 0");
	fetch_fault_a: assert property ( // see (RULE1) (RULE3)
		jrc_take |=> fault_valid_o == $past(jfault) &&
		(!fault_valid_o || fault_o.code == cljd_pkg::FLT_ADDR_FETCH))
		else $error("target fetch fault wrong");
	back_accept_a: assert property ( // see (RULE5)
		redirect_o |-> issue_ready_o)
		else $error("not ready after jump");
	imm_decode_a: assert property ( // see (RULE12) (RULE13)
		take && iop == cljd_pkg::OP_LI |=> wb_valid_o && !fault_valid_o &&
		wb_o.data == dec_imm($past(off12[6:0])))
		else $error("immediate decode wrong");
	byte_addr_a: assert property ( // see (RULE6)
		take && iop == cljd_pkg::OP_LBU |=> mem_req_valid_o &&
		req_addr == $past(issue_src) + $past(boff_sext))
		else $error("byte address wrong");
	zero_ext_a: assert property ( // see (RULE7)
		state == cljd_pkg::ST_LOAD && rsp_ok && mem_req_o.size == cljd_pkg::SZ_BYTE
		|=> wb_valid_o && wb_o.data[31:8] == 24'h0)
		else $error("byte not zero-extended");
	reg_range_a: assert property ( // see (RULE9)
		wb_valid_o && op_q != cljd_pkg::OP_LWP && op_q != cljd_pkg::OP_LWM |->
		(wb_o.idx inside {[5'h2:5'h7], 5'h10, 5'h11}))
		else $error("compact register out of set");
	align_fault_a: assert property ( // see (RULE10) (RULE16)
		take && align_fault && iop != cljd_pkg::OP_LBU && !(iop == cljd_pkg::OP_LWM && list_bad)
		|=> fault_valid_o && fault_o.code == cljd_pkg::FLT_ADDR_LOAD && !mem_req_valid_o)
		else $error("misaligned load not faulted");
	pair_next_a: assert property ( // see (RULE14) (RULE21)
		state == cljd_pkg::ST_LOAD && rsp_ok && !last_beat |=>
		mem_req_valid_o && req_addr == $past(req_addr) + 32'h4)
		else $error("next word address wrong");
	irq_mask_a: assert property ( // see (RULE19)
		mem_req_valid_o && (op_q == cljd_pkg::OP_LWP || op_q == cljd_pkg::OP_LWM) |-> irq_mask_o)
		else $error("interrupts not masked in sequence");
	mem_fault_a: assert property ( // see (RULE20)
		state == cljd_pkg::ST_LOAD && rsp_bad |=> fault_valid_o && !wb_valid_o &&
		fault_o.code == $past(rsp_fault) ##1 issue_ready_o)
		else $error("memory fault not forwarded");
	pc_step_a: assert property ( // see (RULE23)
		take && iop == cljd_pkg::OP_OTHER16 |=> done_o && pc_o == $past(pc_o) + 32'h2)
		else $error("pc not advanced by two");

	jump_back_c: cover property (jrc_take ##1 jrc_take);
	pair_done_c: cover property (op_q == cljd_pkg::OP_LWP && done_o);
	multi_full_c: cover property (op_q == cljd_pkg::OP_LWM && wb_valid_o &&
		wb_o.idx == cljd_pkg::GPR_RA && total_q == 4'ha);
	load_fault_c: cover property (state == cljd_pkg::ST_LOAD && rsp_bad);

endmodule // cljd_core

// >>> tb/cljd_mem_model.sv
`timescale 1ns/1ps
module cljd_mem_model (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic req_valid_i,
	input wire cljd_pkg::cljd_mem_req_s req_i,
	input wire logic [3:0] delay_i,
	input wire logic [31:0] fault_addr_i,
	input wire cljd_pkg::cljd_fault_e fault_i,
	output logic rsp_valid_o,
	output cljd_pkg::cljd_mem_rsp_s rsp_o
);
	logic [3:0] wait_cnt;
	// the request seen in the answer cycle is stale, so it is never answered twice
	wire logic hit = req_valid_i && !rsp_valid_o && (wait_cnt >= delay_i);
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rsp_valid_o <= 1'b0;
			wait_cnt <= 4'h0;
			rsp_o <= '0;
		end else begin
			rsp_valid_o <= hit;
			wait_cnt <= (hit || !req_valid_i || rsp_valid_o) ? 4'h0 : wait_cnt + 4'h1;
			// upper bits carry junk for narrow sizes; data inverts between answers
			rsp_o.data <= hit ? {req_i.addr[15:0] ^ 16'h8c3e, req_i.addr[15:0]} : ~rsp_o.data;
			rsp_o.fault <= (hit && req_i.addr == fault_addr_i) ? fault_i : cljd_pkg::FLT_NONE;
		end
	end
endmodule // cljd_mem_model

// >>> tb/compact_load_jump_decoder_tb.sv
`timescale 1ns/1ps
module compact_load_jump_decoder_tb;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic issue_valid_i = 1'b0;
	cljd_pkg::cljd_issue_s issue_i = '0;
	logic issue_ready_o, mem_req_valid_o, mem_rsp_valid_i, wb_valid_o, redirect_o, flush_o;
	logic encoding_select_flag_o, fault_valid_o, done_o, irq_mask_o;
	logic [31:0] pc_o;
	cljd_pkg::cljd_mem_req_s mem_req_o;
	cljd_pkg::cljd_mem_rsp_s mem_rsp_i;
	cljd_pkg::cljd_wb_s wb_o;
	cljd_pkg::cljd_fault_s fault_o;
	logic [3:0] delay = 4'h0;
	logic [31:0] fault_addr = 32'hffff_ffff;
	cljd_pkg::cljd_fault_e fault_code = cljd_pkg::FLT_NONE;
	int fails = 0;
	int check_count = 0;
	int cycles = 0;
	logic [31:0] q_addr[$];
	logic [1:0] q_size[$];
	logic [36:0] q_wb[$];
	logic got_irq, got_redir;
	logic [2:0] got_flt;
	logic [31:0] got_vaddr, pc0;

	cljd_core uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .issue_valid_i(issue_valid_i),
		.issue_i(issue_i), .issue_ready_o(issue_ready_o), .mem_req_valid_o(mem_req_valid_o),
		.mem_req_o(mem_req_o), .mem_rsp_valid_i(mem_rsp_valid_i), .mem_rsp_i(mem_rsp_i),
		.wb_valid_o(wb_valid_o), .wb_o(wb_o), .redirect_o(redirect_o), .flush_o(flush_o),
		.pc_o(pc_o), .encoding_select_flag_o(encoding_select_flag_o),
		.fault_valid_o(fault_valid_o), .fault_o(fault_o), .done_o(done_o), .irq_mask_o(irq_mask_o));
	cljd_mem_model mem (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_valid_i(mem_req_valid_o),
		.req_i(mem_req_o), .delay_i(delay), .fault_addr_i(fault_addr), .fault_i(fault_code),
		.rsp_valid_o(mem_rsp_valid_i), .rsp_o(mem_rsp_i));

	initial begin
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			end_of_test();
		end
	end

	function automatic logic [31:0] mdata(input logic [31:0] a);
		return {a[15:0] ^ 16'h8c3e, a[15:0]};
	endfunction
	function automatic logic [4:0] mapr(input logic [2:0] c);
		return (c < 3'h2) ? {4'h8, c[0]} : {2'h0, c};
	endfunction
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		if (fails == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// returns in the cycle after the take edge
	// always lets one edge pass, so valid never drops and rises in one time step
	task automatic issue(input cljd_pkg::cljd_op_e op, input logic [31:0] ins, input logic [31:0] src);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end while (issue_ready_o !== 1'b1 && n < 50);
		chk(issue_ready_o, 1'b1);
		pc0 = pc_o;
		issue_valid_i = 1'b1;
		issue_i = '{op, ins, src};
		@(posedge clk_sys_i);
		#1;
		issue_valid_i = 1'b0;
	endtask
	task automatic run(input cljd_pkg::cljd_op_e op, input logic [31:0] ins, input logic [31:0] src);
		int n;
		q_addr.delete();
		q_size.delete();
		q_wb.delete();
		got_irq = 1'b0;
		got_redir = 1'b0;
		got_flt = cljd_pkg::FLT_NONE;
		issue(op, ins, src);
		n = 0;
		while (n < 60) begin
			if ((mem_req_valid_o && mem_rsp_valid_i) === 1'b1) begin
				q_addr.push_back(mem_req_o.addr);
				q_size.push_back(mem_req_o.size);
			end
			if (wb_valid_o === 1'b1) begin
				q_wb.push_back({wb_o.idx, wb_o.data});
			end
			got_irq |= irq_mask_o;
			got_redir |= redirect_o && flush_o;
			if (fault_valid_o === 1'b1) begin
				got_flt = fault_o.code;
				got_vaddr = fault_o.vaddr;
			end
			if ((done_o || fault_valid_o) === 1'b1) begin
				n = 99;
			end else begin
				@(posedge clk_sys_i);
				#1;
				n++;
			end
		end
		// a hung instruction counts as a mismatch
		chk(n, 99);
	endtask

	task automatic t_lbu();
		logic [31:0] ea;
		delay = 4'h2;
		for (int e = 0; e < 16; e++) begin
			ea = 32'h1234 + ((e == 15) ? 32'hffff_ffff : e);
			run(cljd_pkg::OP_LBU, {22'h0, e[2:0], 3'h2, e[3:0]}, 32'h1234);
			chk(q_addr[0], ea);
			chk(q_size[0], cljd_pkg::SZ_BYTE);
			chk(q_wb[0], {mapr(e[2:0]), 24'h0, ea[7:0]});
			chk(pc_o, pc0 + 32'h2);
		end
	endtask
	task automatic t_lhu();
		delay = 4'h0;
		run(cljd_pkg::OP_LHU, {22'h0, 3'h7, 3'h3, 4'h7}, 32'h4000);
		chk(q_addr[0], 32'h400e);
		chk(q_wb[0], {5'h07, 16'h0, 16'h400e});
		run(cljd_pkg::OP_LHU, {22'h0, 3'h7, 3'h3, 4'h7}, 32'h4001);
		chk(got_flt, cljd_pkg::FLT_ADDR_LOAD);
		chk(q_wb.size(), 0);
	endtask
	task automatic t_li();
		logic [6:0] enc[4] = '{7'h00, 7'h03, 7'h7e, 7'h7f};
		logic [31:0] val[4] = '{32'h0, 32'h3, 32'd126, 32'hffff_ffff};
		for (int i = 0; i < 4; i++) begin
			run(cljd_pkg::OP_LI, {22'h0, 3'h1, enc[i]}, 32'h0);
			chk(q_wb[0], {5'h11, val[i]});
			chk(got_flt, cljd_pkg::FLT_NONE);
			chk(pc_o, pc0 + 32'h2);
		end
		// an instruction outside this block only steps the program counter
		run(cljd_pkg::OP_OTHER16, 32'h0, 32'h0);
		chk(q_wb.size(), 0);
		chk(pc_o, pc0 + 32'h2);
	endtask
	task automatic t_short_word_load();
		cljd_pkg::cljd_fault_e fl[4] = '{cljd_pkg::FLT_REFILL, cljd_pkg::FLT_INVALID,
			cljd_pkg::FLT_BUS, cljd_pkg::FLT_WATCH};
		delay = 4'h3;
		run(cljd_pkg::OP_LW, {22'h0, 3'h0, 3'h4, 4'hf}, 32'h8000);
		chk(q_size[0], cljd_pkg::SZ_WORD);
		chk(q_wb[0], {5'h10, mdata(32'h803c)});
		chk(got_irq, 1'b0);
		run(cljd_pkg::OP_LW, {22'h0, 3'h0, 3'h4, 4'hf}, 32'h8002);
		chk(got_flt, cljd_pkg::FLT_ADDR_LOAD);
		fault_addr = 32'h803c;
		for (int i = 0; i < 4; i++) begin
			fault_code = fl[i];
			run(cljd_pkg::OP_LW, {22'h0, 3'h0, 3'h4, 4'hf}, 32'h8000);
			chk(got_flt, fl[i]);
			chk(pc_o, pc0);
		end
		fault_code = cljd_pkg::FLT_NONE;
	endtask
	task automatic t_lwp();
		delay = 4'h1;
		fault_addr = 32'h2000;
		// base register differs from rd, and rd is not 31
		run(cljd_pkg::OP_LWP, {6'h0, 5'h04, 5'h09, 4'h0, 12'hffc}, 32'h2000);
		chk(q_wb[0], {5'h04, mdata(32'h1ffc)});
		chk(q_wb[1], {5'h05, mdata(32'h2000)});
		chk(got_irq, 1'b1);
		chk(pc_o, pc0 + 32'h4);
		fault_code = cljd_pkg::FLT_WATCH;
		run(cljd_pkg::OP_LWP, {6'h0, 5'h04, 5'h09, 4'h0, 12'hffc}, 32'h2000);
		chk(got_flt, cljd_pkg::FLT_WATCH);
		fault_code = cljd_pkg::FLT_NONE;
	endtask
	task automatic t_lwm();
		logic [4:0] lists[4] = '{5'h09, 5'h19, 5'h10, 5'h0a};
		logic [4:0] regs[$];
		for (int i = 0; i < 4; i++) begin
			regs.delete();
			for (int r = 0; r < 8 && r < lists[i][3:0]; r++) begin
				regs.push_back(5'h10 + r[4:0]);
			end
			if (lists[i][3:0] == 4'h9) begin
				regs.push_back(5'h1e);
			end
			if (lists[i][4]) begin
				regs.push_back(5'h1f);
			end
			run(cljd_pkg::OP_LWM, {6'h0, lists[i], 5'h08, 4'h0, 12'h010}, 32'h3000);
			if (lists[i][3:0] > 4'h9) begin
				chk(got_flt, cljd_pkg::FLT_RESERVED);
			end else begin
				chk(q_wb.size(), regs.size());
				foreach (regs[k]) begin
					chk(q_wb[k], {regs[k], mdata(32'h3010 + k * 4)});
				end
			end
		end
	endtask
	task automatic t_jrc();
		run(cljd_pkg::OP_JRC, {22'h0, 5'h04, 5'h03}, 32'h0501);
		chk(got_redir, 1'b1);
		chk(pc_o, 32'h0500);
		chk(encoding_select_flag_o, 1'b1);
		run(cljd_pkg::OP_JRC, {22'h0, 5'h04, 5'h03}, 32'h0602);
		chk(encoding_select_flag_o, 1'b0);
		chk({got_flt, got_vaddr}, {cljd_pkg::FLT_ADDR_FETCH, 32'h0602});
		run(cljd_pkg::OP_JRC, {22'h0, 5'h04, 5'h03}, 32'h0704);
		chk(got_flt, cljd_pkg::FLT_NONE);
	endtask
	// valid stays high across both takes
	task automatic t_b2b();
		@(posedge clk_sys_i);
		#1;
		issue_valid_i = 1'b1;
		issue_i = '{cljd_pkg::OP_JRC, {22'h0, 5'h04, 5'h03}, 32'h0a01};
		@(posedge clk_sys_i);
		#1;
		issue_i = '{cljd_pkg::OP_LI, {22'h0, 3'h2, 7'h05}, 32'h0};
		chk({flush_o, pc_o}, {1'b1, 32'h0a00});
		@(posedge clk_sys_i);
		#1;
		issue_valid_i = 1'b0;
		chk({wb_valid_o, wb_o}, {1'b1, 5'h02, 32'h5});
		chk(pc_o, 32'h0a02);
	endtask

	initial begin
		repeat (2) @(posedge clk_sys_i);
		#1;
		rst_n_i = 1'b1;
		t_lbu();
		t_lhu();
		t_li();
		t_short_word_load();
		t_lwp();
		t_lwm();
		t_jrc();
		t_b2b();
		end_of_test();
	end
endmodule // compact_load_jump_decoder_tb
